//--- core/vip_interrupt_priority_logic.sv
`include "vip_defines.svh"

// Function
// (RULE_01) Simultaneous requests: lowest order number first.
// (RULE_02) Watch overflow order 21, I2C done 22; the code places I2C done at flag bit 24, vector 0034.
// (RULE_03) Monitor select 0: low supply is maskable.
// (RULE_04) Monitor select 1: low supply resets.
// (RULE_05) Serial or async0 done share one flag.
// (RULE_06) One mask bit gates both shared sources.
// (RULE_07) One level bit sets both shared sources.
// (RULE_08) Carrier mode: timer 51 uses carrier signal.
// (RULE_09) Every source has its own request flag.
// (RULE_10) Every source has its own mask flag.
// (RULE_11) Every source has its own level flag.
// (RULE_12) Pins have separate rising and falling enables.
// (RULE_13) Acceptance also needs global and in-service bits.
// (RULE_14) Trap instruction vectors unmasked through 003E.
// (RULE_15) All reset sources share the reset vector.
// (RULE_16) Acknowledge clears the served request flag.
// (RULE_17) Masks load all ones on reset.
// (RULE_18) Trap accepted with global accept cleared.
// (RULE_19) High group may nest into low routines.
module vip_interrupt_priority_logic (
  // Clock and reset.
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  // Register port.
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  // Peripheral event pulses, one bit per flag position.
  input wire logic [31:0] PERIPH_EVENT_I,
  input wire logic SYNC_SERIAL_DONE_I,
  input wire logic ASYNC0_TX_DONE_I,
  input wire logic TIMER51_MATCH_I,
  input wire logic CARRIER_TIMER_SIGNAL_I,
  input wire logic CARRIER_MODE_I,
  input wire logic WATCH_OVERFLOW_I,
  input wire logic I2C_DONE_I,
  // Asynchronous inputs from pins and analog blocks.
  input wire logic [5:0] EXT_PIN_I,
  input wire logic RESET_PIN_I,
  input wire logic POWER_ON_CLEAR_I,
  input wire logic LOW_SUPPLY_I,
  input wire logic WATCHDOG_OVERFLOW_I,
  // CPU core side.
  input wire logic GLOBAL_ACCEPT_I,
  input wire logic IN_SERVICE_LEVEL_I,
  input wire logic TRAP_I,
  input wire logic ACK_I,
  output vip_pkg::vip_req_type REQ_O,
  output logic RESET_REQ_O,
  // Event interrupt.
  output logic IRQ_O
);
  import vip_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [9:0] sync_a;
  logic [9:0] sync_b;
  logic [9:0] sync_c;
  logic [9:0] next_sync_a;
  logic [9:0] next_sync_b;
  logic [9:0] next_sync_c;

  // Two flops per asynchronous input, a third for edge detection.
  always_comb begin
    next_sync_a = {WATCHDOG_OVERFLOW_I, LOW_SUPPLY_I, POWER_ON_CLEAR_I, RESET_PIN_I, EXT_PIN_I};
    next_sync_b = sync_a;
    next_sync_c = sync_b;
    if (RESET_I) begin
      next_sync_a = 10'h000;
      next_sync_b = 10'h000;
      next_sync_c = 10'h000;
    end
  end

  // Registers the synchroniser chain.
  always_ff @(posedge SYS_CLK_I) begin
    sync_a <= next_sync_a;
    sync_b <= next_sync_b;
    sync_c <= next_sync_c;
  end

  logic [5:0] pin_rise;
  logic [5:0] pin_fall;
  logic low_supply_edge;
  logic reset_src_edge;

  // Edge detection on synchronised levels only.
  assign pin_rise = sync_b[5:0] & ~sync_c[5:0];
  assign pin_fall = ~sync_b[5:0] & sync_c[5:0];
  assign low_supply_edge = sync_b[8] & ~sync_c[8];
  assign reset_src_edge = |(sync_b[9:6] & ~sync_c[9:6] & `VIP_RST_SRC_SEL);

  // ----------------------------------------------------------------
  // Register file and pending state
  // ----------------------------------------------------------------
  logic [31:0] flags;
  logic [31:0] masks;
  logic [31:0] levels;
  logic [7:0] rise_en;
  logic [7:0] fall_en;
  logic [7:0] monitor_mode;
  logic [3:0] ev_stat;
  logic [3:0] ev_mask;
  logic trap_pend;
  logic reset_pend;
  logic [31:0] next_flags;
  logic [31:0] next_masks;
  logic [31:0] next_levels;
  logic [7:0] next_rise_en;
  logic [7:0] next_fall_en;
  logic [7:0] next_monitor_mode;
  logic [3:0] next_ev_stat;
  logic [3:0] next_ev_mask;
  logic next_trap_pend;
  logic next_reset_pend;

  // Presented request state.
  vip_kind_type kind;
  vip_kind_type next_kind;
  logic [4:0] win_idx;
  logic [4:0] next_win_idx;
  vip_req_type next_req;
  logic next_reset_req;
  logic next_irq;
  logic [7:0] next_rdata;

  logic [31:0] events;
  logic [31:0] ack_clr;
  logic [3:0] ev_set;
  logic [1:0] byte_sel;
  logic served;
  logic low_to_reset;

  // Lowest set bit index; lower index means earlier default order.
  function automatic logic [5:0] first_set(input logic [31:0] v);
    logic [5:0] r;
    r = 6'h20;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b0, 5'(i)};
      end
    end
    return r;
  endfunction

  // Collects the request events of every maskable source.
  always_comb begin
    events = PERIPH_EVENT_I & `VIP_IMPL_BITS;
    low_to_reset = monitor_mode[`VIP_MONITOR_ACT];
    events[`VIP_BIT_LOW_SUPPLY] = low_supply_edge & ~low_to_reset; // see RULE_03
    events[`VIP_BIT_PIN0 +: 6] = (pin_rise & rise_en[5:0]) | (pin_fall & fall_en[5:0]); // see RULE_12
    events[`VIP_BIT_DUAL] = SYNC_SERIAL_DONE_I | ASYNC0_TX_DONE_I; // see RULE_05
    if (CARRIER_MODE_I) begin
      events[`VIP_BIT_TIMER51] = CARRIER_TIMER_SIGNAL_I; // see RULE_08
    end else begin
      events[`VIP_BIT_TIMER51] = TIMER51_MATCH_I;
    end
    events[`VIP_BIT_WATCH] = WATCH_OVERFLOW_I; // see RULE_02
    events[`VIP_BIT_I2C] = I2C_DONE_I; // see RULE_02
  end

  // Acknowledge of the presented request.
  assign served = ACK_I & REQ_O.valid;
  assign byte_sel = ADDR_I[1:0];

  // Computes the next register file contents.
  always_comb begin
    next_flags = flags;
    next_masks = masks;
    next_levels = levels;
    next_rise_en = rise_en;
    next_fall_en = fall_en;
    next_monitor_mode = monitor_mode;
    next_ev_mask = ev_mask;
    ack_clr = 32'h0000_0000;
    if (served && kind == KIND_MASKABLE) begin
      ack_clr[win_idx] = 1'b1; // see RULE_16
    end
    if (WR_I) begin
      if (ADDR_I >= `VIP_ADDR_FLAGS_FIRST && ADDR_I <= `VIP_ADDR_FLAGS_LAST) begin
        next_flags[byte_sel*8 +: 8] = WDATA_I;
      end
      if (ADDR_I >= `VIP_ADDR_MASKS_FIRST && ADDR_I <= `VIP_ADDR_MASKS_LAST) begin
        next_masks[byte_sel*8 +: 8] = WDATA_I; // see RULE_10
      end
      if (ADDR_I >= `VIP_ADDR_LEVELS_FIRST && ADDR_I <= `VIP_ADDR_LEVELS_LAST) begin
        next_levels[byte_sel*8 +: 8] = WDATA_I; // see RULE_11
      end
      if (ADDR_I == `VIP_ADDR_RISE_EN) begin
        next_rise_en = WDATA_I;
      end
      if (ADDR_I == `VIP_ADDR_FALL_EN) begin
        next_fall_en = WDATA_I;
      end
      if (ADDR_I == `VIP_ADDR_MONITOR) begin
        next_monitor_mode = WDATA_I;
      end
      if (ADDR_I == `VIP_ADDR_IMASK) begin
        next_ev_mask = WDATA_I[3:0];
      end
    end
    // New events win over a software or acknowledge clear.
    next_flags = ((next_flags & ~ack_clr) | events) & `VIP_IMPL_BITS; // see RULE_09
    next_masks = next_masks | ~`VIP_IMPL_BITS;
    next_levels = next_levels | ~`VIP_IMPL_BITS;
    if (RESET_I) begin
      next_flags = `VIP_RST_FLAGS;
      next_masks = `VIP_RST_MASKS; // see RULE_17
      next_levels = `VIP_RST_LEVELS;
      next_rise_en = `VIP_RST_BYTE;
      next_fall_en = `VIP_RST_BYTE;
      next_monitor_mode = `VIP_RST_BYTE;
      next_ev_mask = `VIP_RST_IMASK;
    end
  end

  // Computes pending trap and reset requests and event status.
  always_comb begin
    next_trap_pend = trap_pend;
    next_reset_pend = reset_pend;
    if (served && kind == KIND_TRAP) begin
      next_trap_pend = 1'b0;
    end
    if (served && kind == KIND_RESET) begin
      next_reset_pend = 1'b0;
    end
    if (TRAP_I) begin
      next_trap_pend = 1'b1; // see RULE_14
    end
    if (reset_src_edge || (low_supply_edge && low_to_reset)) begin
      next_reset_pend = 1'b1; // see RULE_04, RULE_15
    end
    ev_set = 4'h0;
    ev_set[`VIP_ST_ACK] = served;
    ev_set[`VIP_ST_TRAP] = served && kind == KIND_TRAP;
    ev_set[`VIP_ST_RST] = next_reset_pend & ~reset_pend;
    ev_set[`VIP_ST_LOW] = events[`VIP_BIT_LOW_SUPPLY];
    next_ev_stat = ev_stat;
    if (RD_I && ADDR_I == `VIP_ADDR_ISTAT) begin
      next_ev_stat = 4'h0;
    end
    next_ev_stat = next_ev_stat | ev_set;
    if (RESET_I) begin
      next_trap_pend = 1'b0;
      next_reset_pend = 1'b0;
      next_ev_stat = `VIP_RST_STAT;
    end
  end

  logic [31:0] live;
  logic [31:0] hi_cand;
  logic [31:0] lo_cand;
  logic [5:0] hi_idx;
  logic [5:0] lo_idx;

  // Arbitrates on the values the flags take at this edge.
  always_comb begin
    live = next_flags & ~next_masks; // see RULE_06
    hi_cand = live & ~next_levels; // see RULE_07
    lo_cand = live & next_levels;
    hi_idx = first_set(hi_cand); // see RULE_01
    lo_idx = first_set(lo_cand); // see RULE_01
    next_kind = KIND_NONE;
    next_win_idx = 5'h00;
    next_req = '0;
    if (next_reset_pend) begin
      next_kind = KIND_RESET;
      next_req.vector = `VIP_VEC_RESET; // see RULE_15
    end else if (next_trap_pend) begin
      next_kind = KIND_TRAP; // see RULE_18
      next_req.vector = `VIP_VEC_TRAP;
    end else if (GLOBAL_ACCEPT_I && !hi_idx[5]) begin
      next_kind = KIND_MASKABLE; // see RULE_13, RULE_19
      next_win_idx = hi_idx[4:0];
      next_req.high = 1'b1;
    end else if (GLOBAL_ACCEPT_I && IN_SERVICE_LEVEL_I && !lo_idx[5]) begin
      next_kind = KIND_MASKABLE; // see RULE_13
      next_win_idx = lo_idx[4:0];
    end
    if (next_kind == KIND_MASKABLE) begin
      next_req.vector = `VIP_VEC_BASE + {10'h000, next_win_idx, 1'b0}; // see RULE_02
    end
    next_req.valid = next_kind != KIND_NONE;
    next_reset_req = next_reset_pend;
    next_irq = |(next_ev_stat & ~next_ev_mask);
    if (RESET_I) begin
      next_kind = KIND_NONE;
      next_win_idx = 5'h00;
      next_req = '0;
      next_reset_req = 1'b0;
      next_irq = 1'b0;
    end
  end

  // Read data for the cycle after a read strobe.
  always_comb begin
    next_rdata = 8'h00;
    if (RD_I) begin
      if (ADDR_I >= `VIP_ADDR_FLAGS_FIRST && ADDR_I <= `VIP_ADDR_FLAGS_LAST) begin
        next_rdata = flags[byte_sel*8 +: 8];
      end
      if (ADDR_I >= `VIP_ADDR_MASKS_FIRST && ADDR_I <= `VIP_ADDR_MASKS_LAST) begin
        next_rdata = masks[byte_sel*8 +: 8];
      end
      if (ADDR_I >= `VIP_ADDR_LEVELS_FIRST && ADDR_I <= `VIP_ADDR_LEVELS_LAST) begin
        next_rdata = levels[byte_sel*8 +: 8];
      end
      if (ADDR_I == `VIP_ADDR_RISE_EN) begin
        next_rdata = rise_en;
      end
      if (ADDR_I == `VIP_ADDR_FALL_EN) begin
        next_rdata = fall_en;
      end
      if (ADDR_I == `VIP_ADDR_MONITOR) begin
        next_rdata = monitor_mode;
      end
      if (ADDR_I == `VIP_ADDR_ISTAT) begin
        next_rdata = {4'h0, ev_stat};
      end
      if (ADDR_I == `VIP_ADDR_IMASK) begin
        next_rdata = {4'h0, ev_mask};
      end
    end
    if (RESET_I) begin
      next_rdata = 8'h00;
    end
  end

  // Registers all block state except the synchroniser chain, and all outputs.
  always_ff @(posedge SYS_CLK_I) begin
    flags <= next_flags;
    masks <= next_masks;
    levels <= next_levels;
    rise_en <= next_rise_en;
    fall_en <= next_fall_en;
    monitor_mode <= next_monitor_mode;
    ev_stat <= next_ev_stat;
    ev_mask <= next_ev_mask;
    trap_pend <= next_trap_pend;
    reset_pend <= next_reset_pend;
    kind <= next_kind;
    win_idx <= next_win_idx;
    REQ_O <= next_req;
    RESET_REQ_O <= next_reset_req;
    IRQ_O <= next_irq;
    RDATA_O <= next_rdata;
  end

endmodule

//--- core/vip_defines.svh
`ifndef VIP_DEFINES_SVH
`define VIP_DEFINES_SVH

// ----------------------------------------------------------------
// Register addresses (low byte of the special register area)
// ----------------------------------------------------------------
`define VIP_ADDR_FLAGS_FIRST 8'hE0
`define VIP_ADDR_FLAGS_LAST 8'hE3
`define VIP_ADDR_MASKS_FIRST 8'hE4
`define VIP_ADDR_MASKS_LAST 8'hE7
`define VIP_ADDR_LEVELS_FIRST 8'hE8
`define VIP_ADDR_LEVELS_LAST 8'hEB
`define VIP_ADDR_RISE_EN 8'hEC
`define VIP_ADDR_FALL_EN 8'hED
`define VIP_ADDR_MONITOR 8'hEE
`define VIP_ADDR_ISTAT 8'hEF
`define VIP_ADDR_IMASK 8'hF0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define VIP_RST_FLAGS 32'h0000_0000
`define VIP_RST_MASKS 32'hFFFF_FFFF
`define VIP_RST_LEVELS 32'hFFFF_FFFF
`define VIP_RST_BYTE 8'h00
`define VIP_RST_STAT 4'h0
`define VIP_RST_IMASK 4'hF

// ----------------------------------------------------------------
// Flag positions in the 32-bit concatenation of the four registers
// ----------------------------------------------------------------
`define VIP_IMPL_BITS 32'h012F_FFFF
`define VIP_BIT_LOW_SUPPLY 0
`define VIP_BIT_PIN0 1
`define VIP_BIT_DUAL 10
`define VIP_BIT_TIMER51 19
`define VIP_BIT_WATCH 21
`define VIP_BIT_I2C 24
`define VIP_MONITOR_ACT 1
// Reset pin, power-on clear and watchdog lanes of the synchroniser.
`define VIP_RST_SRC_SEL 4'hB

// ----------------------------------------------------------------
// Vectors and event status bits
// ----------------------------------------------------------------
`define VIP_VEC_RESET 16'h0000
`define VIP_VEC_BASE 16'h0004
`define VIP_VEC_TRAP 16'h003E
`define VIP_ST_ACK 0
`define VIP_ST_TRAP 1
`define VIP_ST_RST 2
`define VIP_ST_LOW 3

`endif

//--- core/vip_pkg.sv
package vip_pkg;

  // Request presented to the CPU core.
  typedef struct packed {
    logic valid;
    logic high;
    logic [15:0] vector;
  } vip_req_type;

  // Kind of the request being presented.
  typedef enum logic [3:0] {
    KIND_NONE = 4'b0001,
    KIND_RESET = 4'b0010,
    KIND_TRAP = 4'b0100,
    KIND_MASKABLE = 4'b1000
  } vip_kind_type;

endpackage

//--- test/vip_ipl_properties.sv
module vip_ipl_properties (
  // Clock and reset.
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  // Register port.
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] RDATA_O,
  // CPU core side.
  input wire logic GLOBAL_ACCEPT_I,
  input wire logic IN_SERVICE_LEVEL_I,
  input wire logic TRAP_I,
  input wire logic ACK_I,
  input wire vip_pkg::vip_req_type REQ_O,
  input wire logic RESET_REQ_O
);
  timeunit 1ns;
  timeprecision 1ps;
  import vip_pkg::*;
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RESET_I);
  // A presented request that is neither the reset nor the trap vector.
  logic maskable;
  assign maskable = REQ_O.valid && REQ_O.vector != 16'h0000 && REQ_O.vector != 16'h003E;
  sequence s_mask_wr;
    WR_I && ADDR_I inside {8'hE4, 8'hE5};
  endsequence
  sequence s_same_rd;
    RD_I && ADDR_I == $past(ADDR_I, 2);
  endsequence
  // A write to mask byte E4 or E5, one idle bus cycle, then a read of the same byte.
  a_mask_readback:
    assert property (s_mask_wr ##1 !WR_I ##1 s_same_rd |=> RDATA_O == $past(WDATA_I, 3))
    else $error("mask byte did not read back");
  a_rdata_idle:
    assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
    else $error("read data outside its slot");
  a_trap_vector:
    assert property (TRAP_I && !RESET_REQ_O |->
      ##[1:2] REQ_O.valid && REQ_O.vector == 16'h003E)
    else $error("trap not presented");
  a_reset_first:
    assert property (RESET_REQ_O && $past(RESET_REQ_O) |->
      REQ_O.valid && REQ_O.vector == 16'h0000)
    else $error("pending reset not presented");
  a_accept_gate:
    assert property (maskable |->
      GLOBAL_ACCEPT_I || $past(GLOBAL_ACCEPT_I) || $past(GLOBAL_ACCEPT_I, 2))
    else $error("request shown with global accept off");
  a_low_gate:
    assert property (maskable && !REQ_O.high |->
      IN_SERVICE_LEVEL_I || $past(IN_SERVICE_LEVEL_I) || $past(IN_SERVICE_LEVEL_I, 2))
    else $error("low group shown while blocked");
  a_ack_clears:
    assert property (ACK_I && maskable |=>
      !(REQ_O.valid && REQ_O.vector == $past(REQ_O.vector)))
    else $error("acknowledged request still shown");
  a_vector_table:
    assert property (REQ_O.valid |-> !REQ_O.vector[0] &&
      REQ_O.vector inside {[16'h0000:16'h002E], 16'h0034, 16'h003E})
    else $error("vector outside the table");
endmodule

bind vip_interrupt_priority_logic vip_ipl_properties u_props (
  .SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
  .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .GLOBAL_ACCEPT_I(GLOBAL_ACCEPT_I),
  .IN_SERVICE_LEVEL_I(IN_SERVICE_LEVEL_I), .TRAP_I(TRAP_I), .ACK_I(ACK_I),
  .REQ_O(REQ_O), .RESET_REQ_O(RESET_REQ_O)
);

//--- test/vip_cpu_model.sv
module vip_cpu_model (
  // Clock, reset and pacing.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic [1:0] delay_i,
  // Request side.
  input wire vip_pkg::vip_req_type req_i,
  output logic ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_cnt;
  // Takes a shown request after delay_i idle cycles, one pulse at a time.
  always_ff @(posedge clk_i) begin
    if (rst_i || !req_i.valid || ack_o) begin
      ack_o <= 1'b0;
      wait_cnt <= 2'h0;
    end else if (en_i && wait_cnt >= delay_i) begin
      ack_o <= 1'b1;
    end else if (en_i) begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end
endmodule

//--- test/vip_interrupt_priority_logic_tb_top.sv
module vip_interrupt_priority_logic_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import vip_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [31:0] periph = 32'h0;
  logic [5:0] ev = 6'h00;
  logic [5:0] pins = 6'h00;
  logic [2:0] rst_src = 3'h0;
  logic carr_mode = 1'b0;
  logic low_sup = 1'b0;
  logic gie = 1'b1;
  logic in_svc_ok = 1'b1;
  logic trap = 1'b0;
  logic cpu_en = 1'b0;
  logic [1:0] cpu_dly = 2'h2;
  logic [7:0] rdata;
  logic ack;
  logic rst_req;
  logic irq;
  vip_req_type req;
  logic [15:0] got [$];
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;

  vip_interrupt_priority_logic DUT (
    .SYS_CLK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr_stb), .RD_I(rd_stb), .RDATA_O(rdata), .PERIPH_EVENT_I(periph),
    .SYNC_SERIAL_DONE_I(ev[5]), .ASYNC0_TX_DONE_I(ev[4]), .TIMER51_MATCH_I(ev[3]),
    .CARRIER_TIMER_SIGNAL_I(ev[2]), .CARRIER_MODE_I(carr_mode),
    .WATCH_OVERFLOW_I(ev[1]), .I2C_DONE_I(ev[0]), .EXT_PIN_I(pins),
    .RESET_PIN_I(rst_src[0]), .POWER_ON_CLEAR_I(rst_src[1]), .LOW_SUPPLY_I(low_sup),
    .WATCHDOG_OVERFLOW_I(rst_src[2]), .GLOBAL_ACCEPT_I(gie), .IN_SERVICE_LEVEL_I(in_svc_ok),
    .TRAP_I(trap), .ACK_I(ack), .REQ_O(req), .RESET_REQ_O(rst_req), .IRQ_O(irq)
  );
  vip_cpu_model cpu (
    .clk_i(clk), .rst_i(rst), .en_i(cpu_en), .delay_i(cpu_dly), .req_i(req), .ack_o(ack)
  );

  initial begin
    forever #10 clk = ~clk;
  end
  // Logs every vector the core takes and cuts a hung run short.
  always @(posedge clk) begin
    if (ack && req.valid) got.push_back(req.vector);
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      test_done;
    end
  end

  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [17:0] s, input logic [17:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("FAIL %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One write cycle, then one idle edge so a strobe never changes twice in a time step.
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    tick(1);
    wr_stb <= 1'b0;
    tick(1);
  endtask
  // One read cycle; the data is judged in the cycle after the strobe, then one idle edge.
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    rd_stb <= 1'b1;
    tick(1);
    rd_stb <= 1'b0;
    chk(rdata, e);
    tick(1);
  endtask
  task automatic pulse(input logic [5:0] v);
    ev <= v;
    tick(1);
    ev <= 6'h00;
    periph <= 32'h0;
    tick(2);
  endtask
  task automatic do_reset;
    rst <= 1'b1;
    tick(8);
    rst <= 1'b0;
    tick(3);
  endtask
  task automatic wait_acks(input int n);
    int k = 0;
    cpu_en <= 1'b1;
    while (got.size() < n && k < 60) begin
      tick(1);
      k++;
    end
    cpu_en <= 1'b0;
  endtask

  task automatic t_regs;
    logic [7:0] mexp [4] = '{8'h00, 8'h00, 8'hD0, 8'hFE};
    for (int i = 0; i < 4; i++) begin
      reg_rd(8'hE4 + 8'(i), 8'hFF);
      reg_wr(8'hE4 + 8'(i), 8'h00);
      reg_rd(8'hE4 + 8'(i), mexp[i]);
      reg_rd(8'hE0 + 8'(i), 8'h00);
    end
    reg_wr(8'hF8, 8'h5A);
    reg_rd(8'hF8, 8'h00);
  endtask
  task automatic t_order;
    logic [15:0] ev_exp [4] = '{16'h0024, 16'h002A, 16'h002E, 16'h0034};
    periph <= 32'h0001_0000;
    pulse(6'h0B);
    chk(req, {2'b10, 16'h0024});
    wait_acks(4);
    foreach (ev_exp[i]) chk(got[i], ev_exp[i]);
    got.delete();
    chk(irq, 1'b0);
    reg_wr(8'hF0, 8'h0E);
    tick(2);
    chk(irq, 1'b1);
    reg_rd(8'hEF, 8'h01);
    tick(2);
    chk(irq, 1'b0);
  endtask
  task automatic t_shared;
    pulse(6'h20);
    reg_rd(8'hE1, 8'h04);
    reg_wr(8'hE9, 8'hFB);
    in_svc_ok <= 1'b0;
    tick(2);
    chk(req, {2'b11, 16'h0018});
    reg_wr(8'hE5, 8'h04);
    tick(2);
    chk(req.valid, 1'b0);
    reg_wr(8'hE1, 8'h00);
    reg_wr(8'hE5, 8'h00);
    reg_wr(8'hE9, 8'hFF);
    in_svc_ok <= 1'b1;
    pulse(6'h10);
    chk(req, {2'b10, 16'h0018});
    reg_wr(8'hE1, 8'h00);
  endtask
  task automatic t_carrier;
    carr_mode <= 1'b1;
    pulse(6'h08);
    chk(req.valid, 1'b0);
    pulse(6'h04);
    chk(req, {2'b10, 16'h002A});
    reg_wr(8'hE2, 8'h00);
    carr_mode <= 1'b0;
  endtask
  task automatic t_trap;
    gie <= 1'b0;
    pulse(6'h02);
    chk(req.valid, 1'b0);
    trap <= 1'b1;
    tick(1);
    trap <= 1'b0;
    tick(1);
    chk({req.valid, req.vector}, 17'h1003E);
    cpu_dly <= 2'h0;
    gie <= 1'b1;
    wait_acks(2);
    chk(got[0], 16'h003E);
    chk(got[1], 16'h002E);
  endtask
  task automatic t_pins;
    reg_wr(8'hEC, 8'h01);
    pins <= 6'h01;
    tick(5);
    reg_rd(8'hE0, 8'h02);
    reg_wr(8'hE0, 8'h00);
    reg_wr(8'hEC, 8'h00);
    reg_wr(8'hED, 8'h01);
    pins <= 6'h00;
    tick(5);
    reg_rd(8'hE0, 8'h02);
    reg_wr(8'hE0, 8'h00);
    pins <= 6'h01;
    tick(5);
    reg_rd(8'hE0, 8'h00);
  endtask
  task automatic t_supply;
    low_sup <= 1'b1;
    tick(5);
    reg_rd(8'hE0, 8'h01);
    low_sup <= 1'b0;
    reg_wr(8'hE0, 8'h00);
    reg_wr(8'hEE, 8'h02);
    tick(3);
    low_sup <= 1'b1;
    tick(5);
    chk({rst_req, req.valid, req.vector}, 18'h30000);
    reg_rd(8'hE0, 8'h00);
    low_sup <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      do_reset;
      rst_src <= 3'(1 << i);
      tick(5);
      chk({rst_req, req.valid, req.vector}, 18'h30000);
      rst_src <= 3'h0;
    end
  endtask

  // Main sequence of scenarios.
  initial begin
    do_reset;
    t_regs;
    t_order;
    t_shared;
    t_carrier;
    t_trap;
    t_pins;
    t_supply;
    test_done;
  end
endmodule
